// ==== common/return_defines.svh ====
// Constants for the subroutine-return decode block.
// Assumes a 14-bit instruction word and an 8-bit accumulator.
`ifndef RETURN_DEFINES_SVH
`define RETURN_DEFINES_SVH

`define INSN_WIDTH         14
`define DATA_WIDTH         8
`define PC_WIDTH           13
`define LIT_MSB            7
`define LIT_LSB            0
`define RETLIT_HI_MSB      13
`define RETLIT_HI_LSB      10
`define RETLIT_HI_PATTERN  4'hD
`define RETURN_PATTERN     14'h0008
`define PHASE_COUNT        4
`define PHASE_Q1           2'h0
`define PHASE_Q2           2'h1
`define PHASE_Q3           2'h2
`define PHASE_Q4           2'h3

`endif

// ==== common/return_pkg.sv ====
// Types for the subroutine-return decode block.
// Assumes return_defines.svh is on the include path.
package return_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_RETURN_WITH_LITERAL,
    OP_RETURN_PLAIN
  } op_type;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_EXEC,
    ST_FLUSH
  } state_type;
endpackage

// ==== common/decode_if.sv ====
// Carrier between the opcode matcher and the sequencer.
// Assumes both ends share one instruction word.
`include "return_defines.svh"
interface decode_if;
  logic [`INSN_WIDTH-1:0] insn;
  return_pkg::op_type     op;

  modport matcher (
    input  insn,
    output op
  );
  modport user (
    output insn,
    input  op
  );
endinterface

// ==== core/return_opcode_match.sv ====
// Matcher that classifies an instruction word as one of the two returns, or as no return.
// Assumes the word is stable while it is being decoded.
`include "return_defines.svh"
module return_opcode_match (
  decode_if.matcher dec
);
  always_comb begin
    if (dec.insn == `RETURN_PATTERN) begin // [RULE6]
      dec.op = return_pkg::OP_RETURN_PLAIN;
    end else if (dec.insn[`RETLIT_HI_MSB:`RETLIT_HI_LSB] == `RETLIT_HI_PATTERN) begin // [RULE1]
      dec.op = return_pkg::OP_RETURN_WITH_LITERAL;
    end else begin
      dec.op = return_pkg::OP_NONE;
    end
  end
endmodule

// ==== core/subroutine_return_execution.sv ====
// Sequencer for the two subroutine-return instructions.
// Assumes q_phase counts Q1..Q4 of each instruction cycle on ref_clk and that the
// return stack applies a pop in the cycle that stack_pop is high.
`include "return_defines.svh"

// Contract
// [RULE1] The literal-return opcode (11 01xx kkkk kkkk) copies its low byte into the accumulator.
// [RULE2] The literal-return opcode pops the return stack and loads the popped address into the program counter.
// [RULE3] The literal-return takes two instruction cycles, writing and popping in the last phase of the first.
// [RULE4] The plain return pops the return stack into the program counter and leaves the accumulator alone.
// [RULE5] The plain return takes two instruction cycles, popping in the last phase of the first, the second idle.
// [RULE6] The plain return is recognised only from the exact word 00 0000 0000 1000.
// [RULE7] Neither return changes the carry, digit-carry or zero flags.
module subroutine_return_execution #(
  parameter int INSN_W = `INSN_WIDTH,
  parameter int DATA_W = `DATA_WIDTH,
  parameter int PC_W   = `PC_WIDTH
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [1:0]        q_phase,
  input  wire logic              insn_valid,
  input  wire logic [INSN_W-1:0] insn,
  input  wire logic [PC_W-1:0]   top_of_return_stack,
  output logic                   stack_pop,
  output logic [PC_W-1:0]        pc_load_value,
  output logic                   pc_load,
  output logic [DATA_W-1:0]      acc_value,
  output logic                   acc_write,
  output logic                   flags_write,
  output logic                   busy,
  output logic                   flush
);
  // Field positions below assume these widths, so other values are refused
  if (INSN_W != `INSN_WIDTH) begin : g_insn_width
    $error("subroutine_return_execution: INSN_W must equal the instruction word width");
  end
  if (DATA_W != `DATA_WIDTH) begin : g_data_width
    $error("subroutine_return_execution: DATA_W must equal the literal width");
  end
  if (PC_W < 1) begin : g_pc_width
    $error("subroutine_return_execution: PC_W must be at least one");
  end
  if (`LIT_MSB - `LIT_LSB + 1 != DATA_W) begin : g_lit_field
    $error("subroutine_return_execution: literal field does not match DATA_W");
  end
  if (`RETLIT_HI_MSB >= INSN_W) begin : g_op_field
    $error("subroutine_return_execution: opcode field lies outside the word");
  end

  decode_if dec ();

  return_opcode_match u_match (
    .dec (dec)
  );

  assign dec.insn = insn;

  return_pkg::state_type state_reg;
  return_pkg::state_type state_next;
  return_pkg::op_type    op_reg;
  return_pkg::op_type    op_next;
  logic [DATA_W-1:0]     lit_reg;
  logic [DATA_W-1:0]     lit_next;
  logic                  pop_reg;
  logic                  pop_next;
  logic                  acc_we_reg;
  logic                  acc_we_next;
  logic [PC_W-1:0]       pc_reg;
  logic [PC_W-1:0]       pc_next;
  logic [DATA_W-1:0]     acc_reg;
  logic [DATA_W-1:0]     acc_next;
  logic                  take;
  logic                  exec_q3;
  logic                  exec_end;
  logic                  flush_end;
  logic                  op_is_literal;

  // Decode is taken only at Q1 of an idle cycle so a word is never acted on twice
  assign take = (state_reg == return_pkg::ST_FETCH) && insn_valid && (q_phase == `PHASE_Q1)
                && (dec.op != return_pkg::OP_NONE); // [RULE1] [RULE6]
  assign exec_q3       = (state_reg == return_pkg::ST_EXEC) && (q_phase == `PHASE_Q3);
  assign exec_end      = (state_reg == return_pkg::ST_EXEC) && (q_phase == `PHASE_Q4);
  assign flush_end     = (state_reg == return_pkg::ST_FLUSH) && (q_phase == `PHASE_Q4);
  assign op_is_literal = (op_reg == return_pkg::OP_RETURN_WITH_LITERAL);

  // First cycle executes, second cycle idles while the pipeline refills
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      return_pkg::ST_FETCH: begin
        if (take) begin
          state_next = return_pkg::ST_EXEC;
        end
      end
      return_pkg::ST_EXEC: begin
        if (exec_end) begin
          state_next = return_pkg::ST_FLUSH; // [RULE3] [RULE5]
        end
      end
      return_pkg::ST_FLUSH: begin
        if (flush_end) begin
          state_next = return_pkg::ST_FETCH; // [RULE3] [RULE5]
        end
      end
      default: begin
        state_next = return_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= return_pkg::ST_FETCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // Kind is held for the whole return so a later word cannot alter it
  always_comb begin
    op_next = op_reg;
    if (take) begin
      op_next = dec.op;
    end else if (flush_end) begin
      op_next = return_pkg::OP_NONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_reg <= return_pkg::OP_NONE;
    end else begin
      op_reg <= op_next;
    end
  end

  always_comb begin
    lit_next = lit_reg;
    if (take) begin
      lit_next = insn[`LIT_MSB:`LIT_LSB]; // [RULE1]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lit_reg <= '0;
    end else begin
      lit_reg <= lit_next;
    end
  end

  // Registered at Q3 so the pop lands in Q4 of the first cycle
  always_comb begin
    pop_next = 1'b0;
    if (exec_q3) begin
      pop_next = 1'b1; // [RULE2] [RULE3] [RULE4] [RULE5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pop_reg <= 1'b0;
    end else begin
      pop_reg <= pop_next;
    end
  end

  always_comb begin
    acc_we_next = 1'b0;
    if (exec_q3) begin
      acc_we_next = op_is_literal; // [RULE1] [RULE4]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_we_reg <= 1'b0;
    end else begin
      acc_we_reg <= acc_we_next;
    end
  end

  // Stack top must be valid at Q3; a later change is not seen
  always_comb begin
    pc_next = pc_reg;
    if (exec_q3) begin
      pc_next = top_of_return_stack; // [RULE2] [RULE4]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_reg <= '0;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Holds afterwards so the loaded literal stays readable
  always_comb begin
    acc_next = acc_reg;
    if (exec_q3 && op_is_literal) begin
      acc_next = lit_reg; // [RULE1]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign stack_pop     = pop_reg;
  assign pc_load       = pop_reg; // [RULE2] [RULE4]
  assign pc_load_value = pc_reg;
  assign acc_write     = acc_we_reg;
  assign acc_value     = acc_reg;
  assign flags_write   = 1'b0; // [RULE7]
  assign busy          = (state_reg != return_pkg::ST_FETCH);
  assign flush         = (state_reg == return_pkg::ST_FLUSH);
endmodule

// ==== sim/ret_props.sv ====
// Checker for the return sequencer, bound to its top-level ports.
// Assumes q_phase steps once per ref_clk and rst is synchronous.
module ret_props #(
  parameter int INSN_W = 14,
  parameter int DATA_W = 8,
  parameter int PC_W   = 13
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [1:0]        q_phase,
  input wire logic              insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [PC_W-1:0]   top_of_return_stack,
  input wire logic              stack_pop,
  input wire logic [PC_W-1:0]   pc_load_value,
  input wire logic              pc_load,
  input wire logic [DATA_W-1:0] acc_value,
  input wire logic              acc_write,
  input wire logic              flags_write,
  input wire logic              busy,
  input wire logic              flush
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire lit  = insn[13:10] == 4'hD;
  // Busy gates the take, so words arriving mid-return never count
  wire take = q_phase == 2'h0 && insn_valid && !busy && (lit || insn == 14'h0008);
  sequence s_busy; busy [*7]; endsequence
  sequence s_flush; flush [*4] ##1 !flush; endsequence
  chk_lit_acc: assert property (take && lit |-> ##3 acc_write && acc_value == $past(insn[7:0], 3))
    else $error("literal not loaded");
  chk_pop_pc: assert property (take |-> ##3 stack_pop && pc_load && pc_load_value == $past(top_of_return_stack))
    else $error("return address not loaded");
  chk_busy_span: assert property (take |-> ##1 s_busy ##1 !busy)
    else $error("busy span wrong");
  chk_pop_phase: assert property (stack_pop |-> q_phase == 2'h3 ##1 !stack_pop)
    else $error("pop outside last phase");
  chk_plain_keep: assert property (take && !lit |-> ##3 stack_pop && !acc_write)
    else $error("plain return wrote accumulator");
  chk_flush_span: assert property (take |-> ##4 s_flush)
    else $error("idle cycle wrong");
  chk_exact_word: assert property (stack_pop |-> $past(take, 3))
    else $error("pop without matching word");
  chk_flags_never: assert property (!flags_write)
    else $error("flags written");
endmodule
bind subroutine_return_execution ret_props #(.INSN_W(INSN_W), .DATA_W(DATA_W), .PC_W(PC_W)) i_ret_props (
  .ref_clk(ref_clk), .rst(rst), .q_phase(q_phase), .insn_valid(insn_valid), .insn(insn),
  .top_of_return_stack(top_of_return_stack), .stack_pop(stack_pop), .pc_load_value(pc_load_value),
  .pc_load(pc_load), .acc_value(acc_value), .acc_write(acc_write), .flags_write(flags_write),
  .busy(busy), .flush(flush));

// ==== sim/subroutine_return_execution_bench.sv ====
// Self-checking bench for the return sequencer.
// Assumes the bench supplies q_phase, one step per clock.
module subroutine_return_execution_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, rst = 1, insn_valid = 0, stack_pop, pc_load, acc_write, flags_write, busy, flush;
  logic [1:0]  q_phase = 0;
  logic [13:0] insn = 0;
  logic [12:0] top_of_return_stack = 0, pc_load_value, tos_q;
  logic [7:0]  acc_value, macc = 0;
  int          errors = 0, comparisons = 0;
  bit          take, second = 0, lit;
  subroutine_return_execution i_subroutine_return_execution (.ref_clk(ref_clk), .rst(rst), .q_phase(q_phase),
    .insn_valid(insn_valid), .insn(insn), .top_of_return_stack(top_of_return_stack), .stack_pop(stack_pop),
    .pc_load_value(pc_load_value), .pc_load(pc_load), .acc_value(acc_value), .acc_write(acc_write),
    .flags_write(flags_write), .busy(busy), .flush(flush));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk_flag(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin errors++; $display("MISMATCH %s expected %b seen %b", n, e, g); end
  endtask
  task automatic chk_word(string n, logic [12:0] e, logic [12:0] g);
    comparisons++;
    if (g !== e) begin errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One instruction cycle; the model refuses words during the idle cycle
  task automatic instr(logic [13:0] w, logic v);
    lit = w[13:10] == 4'hD;
    take = !second && v && (lit || w == 14'h0008);
    for (int p = 0; p < 4; p++) begin
      q_phase = p[1:0];
      if (p == 0) begin insn = w; insn_valid = v; end
      // Stack top changes every clock, so only the Q3 sample may reach the counter
      top_of_return_stack = 13'($urandom);
      if (p == 2) tos_q = top_of_return_stack;
      chk_flag("busy", second || (take && p != 0), busy);
      chk_flag("flush", second, flush);
      if (p == 3 && take && lit) macc = w[7:0];
      chk_flag("stack_pop", take && p == 3, stack_pop);
      chk_flag("pc_load", take && p == 3, pc_load);
      chk_flag("acc_write", take && lit && p == 3, acc_write);
      chk_flag("flags_write", 1'b0, flags_write);
      chk_word("acc_value", 13'(macc), 13'(acc_value));
      if (take && p == 3) chk_word("pc_load_value", tos_q, pc_load_value);
      @(negedge ref_clk);
    end
    second = take;
  endtask
  initial begin
    int          k;
    logic [13:0] w;
    void'($urandom(15671));
    repeat (12) @(negedge ref_clk);
    rst = 0;
    instr(14'h3455, 1);
    instr(14'h0008, 1);
    instr(14'h0008, 1);
    for (int i = 0; i < 300; i++) begin
      k = $urandom % 4;
      w = k == 0 ? {4'hD, 10'($urandom)} : k == 1 ? 14'h0008 :
          k == 2 ? 14'h0008 ^ (14'h0001 << ($urandom % 14)) : 14'($urandom);
      instr(w, $urandom % 8 != 0);
    end
    end_of_test();
  end
  initial begin
    #100us;
    errors++;
    end_of_test();
  end
endmodule
